// ==== shared/irq_bank_pkg.sv ====
// Purpose: shared constants and types for the interrupt flag/enable bank
// Assumes: 32-bit AXI4-Lite register bus, byte-wide registers in low lanes
// Notes: offsets are byte addresses of aligned words
package irq_bank_pkg;
  localparam int ADDR_W = 5;
  // register byte offsets
  localparam logic [4:0] OFS_EDGE = 5'h00;
  localparam logic [4:0] OFS_CTRL_A = 5'h04;
  localparam logic [4:0] OFS_CTRL_B = 5'h08;
  localparam logic [4:0] OFS_GRP_A = 5'h0C;
  localparam logic [4:0] OFS_GRP_B = 5'h10;
  // implemented-bit masks
  localparam logic [7:0] MASK_EDGE = 8'h03;
  localparam logic [7:0] MASK_CTRL_A = 8'h7F;
  localparam logic [7:0] MASK_CTRL_B = 8'hFF;
  localparam logic [7:0] MASK_GRP = 8'h33;
  // reset values
  localparam logic [7:0] RST_EDGE = 8'h00;
  localparam logic [7:0] RST_CTRL_A = 8'h00;
  localparam logic [7:0] RST_CTRL_B = 8'h00;
  localparam logic [7:0] RST_GRP = 8'h00;
  // primary control a bit positions
  localparam int BIT_TB1_FLAG = 6;
  localparam int BIT_TB0_FLAG = 5;
  localparam int BIT_EXT_FLAG = 4;
  localparam int BIT_TB1_EN = 3;
  localparam int BIT_TB0_EN = 2;
  localparam int BIT_EXT_EN = 1;
  localparam int BIT_GIE = 0;
  // primary control b bit positions
  localparam int BIT_GRP1_FLAG = 7;
  localparam int BIT_ADC_FLAG = 6;
  localparam int BIT_NVM_FLAG = 5;
  localparam int BIT_GRP0_FLAG = 4;
  localparam int BIT_GRP1_EN = 3;
  localparam int BIT_ADC_EN = 2;
  localparam int BIT_NVM_EN = 1;
  localparam int BIT_GRP0_EN = 0;
  // group register bit positions
  localparam int BIT_CMPA_FLAG = 5;
  localparam int BIT_CMPP_FLAG = 4;
  localparam int BIT_CMPA_EN = 1;
  localparam int BIT_CMPP_EN = 0;
  // edge select codes
  localparam logic [1:0] EDGE_OFF = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_FALL = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // vector sources, index into pending vector
  typedef enum logic [2:0] {
    SRC_EXT = 3'h0,
    SRC_TB0 = 3'h1,
    SRC_TB1 = 3'h2,
    SRC_GRP0 = 3'h3,
    SRC_NVM = 3'h4,
    SRC_ADC = 3'h5,
    SRC_GRP1 = 3'h6
  } src_t;
  localparam int NUM_SRC = 7;
  // one-cycle event pulses from internal peripherals
  typedef struct packed {
    logic tb1;
    logic tb0;
    logic nvm;
    logic adc;
    logic stdCmpa;
    logic stdCmpp;
    logic perCmpa;
    logic perCmpp;
  } irq_evt_t;
endpackage

// ==== hw/pin_sync.sv ====
// Purpose: two-flop synchroniser for asynchronous pin levels
// Assumes: input may change at any time relative to sys_clk
// Notes: first stage feeds only the second stage
`default_nettype none
module pin_sync #(
  parameter int W = 1
) (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic [W-1:0] pinIn, // raw pin level
  output logic [W-1:0] pinOut // synchronised level
);
  logic [W-1:0] meta_q;
  // two stages, metastability settles in the first
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      pinOut <= '0;
    end else begin
      meta_q <= pinIn;
      pinOut <= meta_q;
    end
  end
endmodule
`default_nettype wire

// ==== hw/pin_edge_detect.sv ====
// Purpose: selectable edge detector for the external interrupt pin
// Assumes: input already synchronised to sys_clk
// Notes: output is a registered one-cycle pulse
`default_nettype none
module pin_edge_detect (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, active low
  input wire logic level, // synchronised pin level
  input wire logic [1:0] edgeSel, // edge select field
  output logic edgePulse // one-cycle detect pulse
);
  logic prev_q;
  logic rise;
  logic fall;
  // previous level, reset low so a pin high at release looks like a rise
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end
  assign rise = level & ~prev_q;
  assign fall = ~level & prev_q;
  // edge type chosen by the select field, 00 turns it off
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      edgePulse <= 1'b0;
    end else begin
      unique case (edgeSel)
        irq_bank_pkg::EDGE_OFF: edgePulse <= 1'b0; // RL1
        irq_bank_pkg::EDGE_RISE: edgePulse <= rise; // RL1
        irq_bank_pkg::EDGE_FALL: edgePulse <= fall; // RL1
        irq_bank_pkg::EDGE_BOTH: edgePulse <= rise | fall; // RL1
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== hw/irq_flag_enable_bank.sv ====
// Purpose: interrupt request flag and enable register bank
// Assumes: AXI4-Lite slave, one write and one read in flight at most
// Notes: internal event inputs are same-clock one-cycle pulses
`default_nettype none
// Operation
// RL1: edge field 00 off, 01 rising, 10 falling, 11 both edges.
// RL2: edge config bits 7 to 2 read as zero.
// RL3: control a bit 7 reads as zero.
// RL4: control a bit 6 is time base 1 request flag.
// RL5: control a bit 5 is time base 0 request flag.
// RL6: control a bit 4 is external pin request flag.
// RL7: control a bit 3 enables time base 1.
// RL8: control a bit 2 enables time base 0.
// RL9: control a bit 1 enables the external pin source.
// RL10: control b bit 7 is group 1 request flag.
// RL11: control b bit 6 is conversion-done request flag.
// RL12: control b bit 5 is data memory request flag.
// RL13: control b bit 4 is group 0 request flag.
// RL14: control b bit 3 enables group 1.
// RL15: control b bit 2 enables the converter source.
// RL16: control b bit 1 enables the data memory source.
// RL17: control b bit 0 enables group 0.
// RL18: flags are software writable; software clears conversion flag before enabling.
// RL19: group registers hold cmpA/cmpP flags in 5/4, enables in 1/0.
// RL20: requests come from pin, timers, time bases, data memory, converter.
// RL21: interrupt needs flag, own enable and global enable all set.
// RL22: taking an interrupt clears global enable; flags keep latching.
// RL23: a group flag sets when any member flag becomes set.
// RL24: pin flag sets on the selected transition of the pin.
// RL25: all implemented bits reset to zero.
module irq_flag_enable_bank (
  input wire logic sys_clk, // system clock
  input wire logic arst_n, // async reset, active low
  // axi4-lite write address
  input wire logic [irq_bank_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  // axi4-lite write data
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte strobes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  // axi4-lite write response
  output logic [1:0] bresp, // write response
  output logic bvalid, // response valid
  input wire logic bready, // response ready
  // axi4-lite read address
  input wire logic [irq_bank_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  // axi4-lite read data
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  // sources
  input wire logic extPin, // external interrupt pin, async
  input wire irq_bank_pkg::irq_evt_t evt, // internal event pulses
  // core side
  input wire logic ackValid, // core takes an interrupt, pulse
  input wire irq_bank_pkg::src_t ackSrc, // vector being taken
  output logic irqReq, // any enabled request pending
  output logic [irq_bank_pkg::NUM_SRC-1:0] pendVec // enabled pending per vector
);
  // register state
  logic [7:0] edge_q;
  logic [7:0] ctrlA_q;
  logic [7:0] ctrlB_q;
  logic [7:0] grpA_q;
  logic [7:0] grpB_q;
  logic [7:0] edge_d;
  logic [7:0] ctrlA_d;
  logic [7:0] ctrlB_d;
  logic [7:0] grpA_d;
  logic [7:0] grpB_d;
  // bus state
  logic awHave_q;
  logic wHave_q;
  logic [irq_bank_pkg::ADDR_W-1:0] wAddr_q;
  logic [7:0] wByte_q;
  logic wLane_q;
  logic wrFire;
  logic arFire;
  logic awHave_d;
  logic wHave_d;
  logic bvalid_d;
  logic rvalid_d;
  // pin path
  logic pinLvl;
  logic pinEdge;
  // event decode
  logic [7:0] wrByte;
  logic [7:0] setA;
  logic [7:0] setB;
  logic [7:0] setGA;
  logic [7:0] setGB;
  logic [7:0] clrA;
  logic [7:0] clrB;
  localparam int NUM_SRC_L = irq_bank_pkg::NUM_SRC;
  logic [NUM_SRC_L-1:0] pend;


  // pin passes two flops before any logic sees it
  pin_sync #(
    .W(1)
  ) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .pinIn(extPin),
    .pinOut(pinLvl)
  );

  pin_edge_detect u_edge (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .level(pinLvl),
    .edgeSel(edge_q[1:0]),
    .edgePulse(pinEdge)
  );

  // byte write helper, only lane 0 carries a register
  function automatic logic [7:0] wrReg(
    input logic [7:0] old,
    input logic hit,
    input logic [7:0] mask
  );
    wrReg = (hit ? wrByte : old) & mask;
  endfunction

  // address hit test for the pending write
  function automatic logic hitAt(input logic [4:0] ofs);
    hitAt = wrFire && wLane_q && (wAddr_q == ofs);
  endfunction

  // is this offset mapped
  function automatic logic mapped(input logic [4:0] a);
    mapped = (a == irq_bank_pkg::OFS_EDGE) || (a == irq_bank_pkg::OFS_CTRL_A) ||
      (a == irq_bank_pkg::OFS_CTRL_B) || (a == irq_bank_pkg::OFS_GRP_A) ||
      (a == irq_bank_pkg::OFS_GRP_B);
  endfunction

  assign wrByte = wByte_q;
  // write commits once both halves are held and no response is waiting
  assign wrFire = awHave_q && wHave_q && !bvalid;
  assign arFire = arvalid && arready;

  // hardware sets from peripherals; timers land in group registers
  always_comb begin
    setGA = 8'h00;
    setGB = 8'h00;
    setGA[irq_bank_pkg::BIT_CMPA_FLAG] = evt.stdCmpa; // RL19 RL20
    setGA[irq_bank_pkg::BIT_CMPP_FLAG] = evt.stdCmpp; // RL19 RL20
    setGB[irq_bank_pkg::BIT_CMPA_FLAG] = evt.perCmpa; // RL19 RL20
    setGB[irq_bank_pkg::BIT_CMPP_FLAG] = evt.perCmpp; // RL19 RL20
  end

  // member flags: write first, hardware set wins over a clear
  // a process, not assigns, so bus state read inside the helpers wakes it
  always_comb begin
    grpA_d = wrReg(grpA_q, hitAt(irq_bank_pkg::OFS_GRP_A), irq_bank_pkg::MASK_GRP)
      | setGA; // RL18 RL19
    grpB_d = wrReg(grpB_q, hitAt(irq_bank_pkg::OFS_GRP_B), irq_bank_pkg::MASK_GRP)
      | setGB; // RL18 RL19
  end

  // primary sets, including group flags raised by a member becoming set
  always_comb begin
    setA = 8'h00;
    setB = 8'h00;
    setA[irq_bank_pkg::BIT_TB1_FLAG] = evt.tb1; // RL4 RL20
    setA[irq_bank_pkg::BIT_TB0_FLAG] = evt.tb0; // RL5 RL20
    setA[irq_bank_pkg::BIT_EXT_FLAG] = pinEdge; // RL6 RL24
    setB[irq_bank_pkg::BIT_ADC_FLAG] = evt.adc; // RL11 RL20
    setB[irq_bank_pkg::BIT_NVM_FLAG] = evt.nvm; // RL12 RL20
    setB[irq_bank_pkg::BIT_GRP0_FLAG] = |((grpA_d & ~grpA_q) & 8'h30); // RL13 RL23
    setB[irq_bank_pkg::BIT_GRP1_FLAG] = |((grpB_d & ~grpB_q) & 8'h30); // RL10 RL23
  end

  // taking a vector drops global enable and that vector's own flag
  always_comb begin
    clrA = 8'h00;
    clrB = 8'h00;
    if (ackValid) begin
      clrA[irq_bank_pkg::BIT_GIE] = 1'b1; // RL22
      unique case (ackSrc)
        irq_bank_pkg::SRC_EXT: clrA[irq_bank_pkg::BIT_EXT_FLAG] = 1'b1;
        irq_bank_pkg::SRC_TB0: clrA[irq_bank_pkg::BIT_TB0_FLAG] = 1'b1;
        irq_bank_pkg::SRC_TB1: clrA[irq_bank_pkg::BIT_TB1_FLAG] = 1'b1;
        irq_bank_pkg::SRC_GRP0: clrB[irq_bank_pkg::BIT_GRP0_FLAG] = 1'b1;
        irq_bank_pkg::SRC_NVM: clrB[irq_bank_pkg::BIT_NVM_FLAG] = 1'b1;
        irq_bank_pkg::SRC_ADC: clrB[irq_bank_pkg::BIT_ADC_FLAG] = 1'b1;
        irq_bank_pkg::SRC_GRP1: clrB[irq_bank_pkg::BIT_GRP1_FLAG] = 1'b1;
        default: clrB = 8'h00;
      endcase
    end
  end

  // write, then ack clear, then set; a new event is never lost
  always_comb begin
    edge_d = wrReg(edge_q, hitAt(irq_bank_pkg::OFS_EDGE), irq_bank_pkg::MASK_EDGE); // RL2
    ctrlA_d = ((wrReg(ctrlA_q, hitAt(irq_bank_pkg::OFS_CTRL_A),
      irq_bank_pkg::MASK_CTRL_A) & ~clrA) | setA) & irq_bank_pkg::MASK_CTRL_A; // RL3 RL18
    ctrlB_d = ((wrReg(ctrlB_q, hitAt(irq_bank_pkg::OFS_CTRL_B),
      irq_bank_pkg::MASK_CTRL_B) & ~clrB) | setB); // RL18
  end

  // register bank; everything implemented starts at zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      edge_q <= irq_bank_pkg::RST_EDGE; // RL25
      ctrlA_q <= irq_bank_pkg::RST_CTRL_A; // RL25
      ctrlB_q <= irq_bank_pkg::RST_CTRL_B; // RL25
      grpA_q <= irq_bank_pkg::RST_GRP; // RL25
      grpB_q <= irq_bank_pkg::RST_GRP; // RL25
    end else begin
      edge_q <= edge_d;
      ctrlA_q <= ctrlA_d;
      ctrlB_q <= ctrlB_d;
      grpA_q <= grpA_d;
      grpB_q <= grpB_d;
    end
  end

  // per-vector gating by own enable and global enable
  always_comb begin
    pend = '0;
    if (ctrlA_q[irq_bank_pkg::BIT_GIE]) begin // RL21
      pend[irq_bank_pkg::SRC_EXT] = ctrlA_q[irq_bank_pkg::BIT_EXT_FLAG] &
        ctrlA_q[irq_bank_pkg::BIT_EXT_EN]; // RL9 RL21
      pend[irq_bank_pkg::SRC_TB0] = ctrlA_q[irq_bank_pkg::BIT_TB0_FLAG] &
        ctrlA_q[irq_bank_pkg::BIT_TB0_EN]; // RL8 RL21
      pend[irq_bank_pkg::SRC_TB1] = ctrlA_q[irq_bank_pkg::BIT_TB1_FLAG] &
        ctrlA_q[irq_bank_pkg::BIT_TB1_EN]; // RL7 RL21
      pend[irq_bank_pkg::SRC_GRP0] = ctrlB_q[irq_bank_pkg::BIT_GRP0_FLAG] &
        ctrlB_q[irq_bank_pkg::BIT_GRP0_EN]; // RL17 RL21
      pend[irq_bank_pkg::SRC_NVM] = ctrlB_q[irq_bank_pkg::BIT_NVM_FLAG] &
        ctrlB_q[irq_bank_pkg::BIT_NVM_EN]; // RL16 RL21
      pend[irq_bank_pkg::SRC_ADC] = ctrlB_q[irq_bank_pkg::BIT_ADC_FLAG] &
        ctrlB_q[irq_bank_pkg::BIT_ADC_EN]; // RL15 RL21
      pend[irq_bank_pkg::SRC_GRP1] = ctrlB_q[irq_bank_pkg::BIT_GRP1_FLAG] &
        ctrlB_q[irq_bank_pkg::BIT_GRP1_EN]; // RL14 RL21
    end
  end

  // request outputs registered, one cycle behind the flags
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      irqReq <= 1'b0;
      pendVec <= '0;
    end else begin
      irqReq <= |pend; // RL21
      pendVec <= pend;
    end
  end

  // write channel holding; address and data may come in either order
  assign awHave_d = wrFire ? 1'b0 : (awHave_q | (awvalid & awready));
  assign wHave_d = wrFire ? 1'b0 : (wHave_q | (wvalid & wready));
  assign bvalid_d = wrFire ? 1'b1 : (bvalid & ~bready);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      awHave_q <= 1'b0;
      wHave_q <= 1'b0;
      awready <= 1'b0;
      wready <= 1'b0;
      bvalid <= 1'b0;
    end else begin
      awHave_q <= awHave_d;
      wHave_q <= wHave_d;
      // ready drops as soon as a half is held, so payload is stored once
      awready <= ~awHave_d & ~bvalid_d & ~wrFire;
      wready <= ~wHave_d & ~bvalid_d & ~wrFire;
      bvalid <= bvalid_d;
    end
  end

  // capture write payload on its own handshake
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wAddr_q <= '0;
      wByte_q <= 8'h00;
      wLane_q <= 1'b0;
      bresp <= irq_bank_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        wAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wByte_q <= wdata[7:0];
        wLane_q <= wstrb[0];
      end
      if (wrFire) begin
        bresp <= mapped(wAddr_q) ? irq_bank_pkg::RESP_OKAY : irq_bank_pkg::RESP_SLVERR;
      end
    end
  end

  // read channel: answer one cycle after the address is taken
  assign rvalid_d = arFire ? 1'b1 : (rvalid & ~rready);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      arready <= 1'b0;
      rvalid <= 1'b0;
    end else begin
      arready <= ~rvalid_d;
      rvalid <= rvalid_d;
    end
  end

  // read mux; unimplemented bits are zero in storage already
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= 32'h0000_0000;
      rresp <= irq_bank_pkg::RESP_OKAY;
    end else if (arFire) begin
      rresp <= mapped(araddr) ? irq_bank_pkg::RESP_OKAY : irq_bank_pkg::RESP_SLVERR;
      unique case (araddr)
        irq_bank_pkg::OFS_EDGE: rdata <= {24'h000000, edge_q}; // RL1 RL2
        irq_bank_pkg::OFS_CTRL_A: rdata <= {24'h000000, ctrlA_q}; // RL3
        irq_bank_pkg::OFS_CTRL_B: rdata <= {24'h000000, ctrlB_q};
        irq_bank_pkg::OFS_GRP_A: rdata <= {24'h000000, grpA_q}; // RL19
        irq_bank_pkg::OFS_GRP_B: rdata <= {24'h000000, grpB_q}; // RL19
        default: rdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ==== verification/irq_bank_props.sv ====
// Purpose: port checks for the flag bank
// Assumes: one clock, async low reset
// Notes: bound into the bank
`default_nettype none
module irq_bank_props (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic awvalid, // aw valid
  input wire logic awready, // aw ready
  input wire logic wvalid, // w valid
  input wire logic wready, // w ready
  input wire logic bvalid, // b valid
  input wire logic bready, // b ready
  input wire logic [1:0] bresp, // b resp
  input wire logic [4:0] araddr, // ar addr
  input wire logic arvalid, // ar valid
  input wire logic arready, // ar ready
  input wire logic rvalid, // r valid
  input wire logic rready, // r ready
  input wire logic [31:0] rdata, // r data
  input wire logic ackValid, // core take
  input wire logic irqReq, // request
  input wire logic [6:0] pendVec // pending
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);
  // bus handshakes and spare read-data bits
  sequence s_wr_take; awvalid && awready && wvalid && wready; endsequence
  sequence s_rd_at(logic [4:0] a); arvalid && arready && araddr == a; endsequence
  property p_wr_resp; s_wr_take |-> ##[1:3] bvalid; endproperty
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  property p_rd_resp; arvalid && arready |=> rvalid && rdata[31:8] == 24'h0; endproperty
  property p_edge_rd; s_rd_at(irq_bank_pkg::OFS_EDGE) |=> rdata[7:2] == 6'h00; endproperty
  property p_ctla_rd; s_rd_at(irq_bank_pkg::OFS_CTRL_A) |=> rdata[7] == 1'h0; endproperty
  property p_grp_rd;
    (s_rd_at(irq_bank_pkg::OFS_GRP_A) or s_rd_at(irq_bank_pkg::OFS_GRP_B))
      |=> (rdata[7:0] & ~irq_bank_pkg::MASK_GRP) == 8'h00;
  endproperty
  // a taken interrupt must silence every vector
  property p_ack_clr; ackValid |-> ##2 pendVec == 7'h00; endproperty
  property p_req_lo; (pendVec == 7'h00) [*2] |-> !irqReq; endproperty
  property p_req_hi; (pendVec != 7'h00) [*2] |-> irqReq; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("no write response");
  a_b_hold: assert property (p_b_hold) else $error("b dropped");
  a_r_hold: assert property (p_r_hold) else $error("r dropped");
  a_rd_resp: assert property (p_rd_resp) else $error("bad read reply");
  a_edge_rd: assert property (p_edge_rd) else $error("edge upper bits");
  a_ctla_rd: assert property (p_ctla_rd) else $error("ctrl a bit 7");
  a_grp_rd: assert property (p_grp_rd) else $error("group spare bits");
  a_ack_clr: assert property (p_ack_clr) else $error("pending after take");
  a_req_lo: assert property (p_req_lo) else $error("request without pending");
  a_req_hi: assert property (p_req_hi) else $error("pending without request");
endmodule
bind irq_flag_enable_bank irq_bank_props irq_bank_props_inst (.*);
`default_nettype wire

// ==== verification/core_model.sv ====
// Purpose: core that takes interrupts from the bank
// Assumes: one take per request, lowest vector first
// Notes: waits for the request to drop before taking again
`default_nettype none
module core_model (
  input wire logic sys_clk, // clock
  input wire logic arst_n, // reset
  input wire logic pEn, // model active
  input wire logic [3:0] pLag, // cycles before take
  input wire logic irqReq, // request in
  input wire logic [6:0] pendVec, // pending in
  output logic ackValid, // take pulse
  output irq_bank_pkg::src_t ackSrc // vector taken
);
  logic [3:0] lag_q;
  logic busy_q;
  function automatic irq_bank_pkg::src_t pick(logic [6:0] p);
    pick = irq_bank_pkg::SRC_EXT;
    for (int i = 6; i >= 0; i--) if (p[i]) pick = irq_bank_pkg::src_t'(3'(i));
  endfunction
  // take after the lag; vector bus toggles when idle so stale values never look valid
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ackValid <= 1'h0;
      ackSrc <= irq_bank_pkg::SRC_EXT;
      busy_q <= 1'h0;
      lag_q <= 4'h0;
    end else begin
      ackValid <= 1'h0;
      ackSrc <= irq_bank_pkg::src_t'(~ackSrc);
      if (busy_q) begin
        busy_q <= irqReq;
      end else if (pEn && irqReq && lag_q >= pLag) begin
        ackValid <= 1'h1;
        ackSrc <= pick(pendVec);
        busy_q <= 1'h1;
        lag_q <= 4'h0;
      end else begin
        lag_q <= (pEn && irqReq) ? lag_q + 4'h1 : 4'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
// Purpose: self-checking bench for the flag bank
// Assumes: package offsets and masks
// Notes: random data from a fixed-seed xorshift
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin n_fail++; \
  $display("Error t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [4:0] awaddr = 5'h00;
  logic [4:0] araddr = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic [3:0] wstrb = 4'h0;
  logic [3:0] st = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic extPin = 1'h0, pEn = 1'h0;
  logic [3:0] pLag = 4'h0;
  irq_bank_pkg::irq_evt_t evt = '0;
  logic awready, wready, bvalid, arready, rvalid, ackValid, irqReq;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, v;
  logic [6:0] pendVec;
  irq_bank_pkg::src_t ackSrc;
  logic [31:0] seed = 32'hFECAEEC4;
  int n_fail = 0, checked = 0, n, i;
  irq_flag_enable_bank irq_flag_enable_bank_inst (.*);
  core_model core_model_inst (.*);
  always #5 sys_clk = ~sys_clk;
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // implemented bits of register k (offset k*4)
  function automatic logic [7:0] msk(int k);
    case (k)
      0: return irq_bank_pkg::MASK_EDGE;
      1: return irq_bank_pkg::MASK_CTRL_A;
      2: return irq_bank_pkg::MASK_CTRL_B;
      default: return irq_bank_pkg::MASK_GRP;
    endcase
  endfunction
  // {ctrl a, ctrl b, group} after event bit n; timer events also raise their group flag
  function automatic logic [23:0] ev(int n);
    case (n)
      0: return 24'h008010;
      1: return 24'h008020;
      2: return 24'h001010;
      3: return 24'h001020;
      4: return 24'h004000;
      5: return 24'h002000;
      6: return 24'h200000;
      default: return 24'h400000;
    endcase
  endfunction
  // pending vector after event bit n with every control a and b enable and global enable on
  function automatic logic [6:0] pv(int n);
    case (n)
      0, 1: return 7'h01 << irq_bank_pkg::SRC_GRP1;
      2, 3: return 7'h01 << irq_bank_pkg::SRC_GRP0;
      4: return 7'h01 << irq_bank_pkg::SRC_ADC;
      5: return 7'h01 << irq_bank_pkg::SRC_NVM;
      6: return 7'h01 << irq_bank_pkg::SRC_TB0;
      default: return 7'h01 << irq_bank_pkg::SRC_TB1;
    endcase
  endfunction
  task automatic stop_test(input logic to);
    if (to) n_fail++;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // one write; each channel dropped at its own handshake
  task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] er);
    int k;
    @(posedge sys_clk);
    awaddr <= a;
    wdata <= {xs() & 32'hFFFFFF00} | {24'h0, d};
    wstrb <= st;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (bvalid) break;
    end
    if (k == 64) stop_test(1'h1);
    `CHK(bresp, er)
    bready <= 1'h0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    for (k = 0; k < 64; k++) begin
      @(posedge sys_clk);
      if (arready) arvalid <= 1'h0;
      if (rvalid) break;
    end
    if (k == 64) stop_test(1'h1);
    d = rdata;
    `CHK(rresp, er)
    rready <= 1'h0;
  endtask
  task automatic rc(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] d;
    rd(a, d, irq_bank_pkg::RESP_OKAY);
    `CHK(d, {24'h0, e})
  endtask
  task automatic clr();
    for (int k = 0; k < 5; k++) wr(5'(k * 4), 8'h00, irq_bank_pkg::RESP_OKAY);
  endtask
  initial begin
    repeat (12) @(posedge sys_clk);
    arst_n <= 1'h1;
    repeat (2) @(posedge sys_clk);
    for (n = 0; n < 5; n++) rc(5'(n * 4), 8'h00);
    rd(5'h14, v, irq_bank_pkg::RESP_SLVERR);
    `CHK(v, 32'h0)
    wr(5'h1C, 8'hFF, irq_bank_pkg::RESP_SLVERR);
    // lane 0 strobe low: the write is answered but lands nowhere
    st = 4'hE;
    wr(irq_bank_pkg::OFS_CTRL_B, 8'hFF, irq_bank_pkg::RESP_OKAY);
    st = 4'hF;
    rc(irq_bank_pkg::OFS_CTRL_B, 8'h00);
    $display("test reset done");
    // random data, spare bits must read zero
    for (n = 0; n < 15; n++) begin
      v = xs();
      wr(5'((n % 5) * 4), v[7:0], irq_bank_pkg::RESP_OKAY);
      rc(5'((n % 5) * 4), v[7:0] & msk(n % 5));
    end
    clr();
    $display("test regs done");
    for (n = 0; n < 8; n++) begin
      // every control a and b enable on, group enables off, core model idle, so the pending vector stands
      wr(irq_bank_pkg::OFS_CTRL_A, 8'h0F, irq_bank_pkg::RESP_OKAY);
      wr(irq_bank_pkg::OFS_CTRL_B, 8'h0F, irq_bank_pkg::RESP_OKAY);
      @(posedge sys_clk);
      evt <= irq_bank_pkg::irq_evt_t'(8'h01 << n);
      @(posedge sys_clk);
      evt <= '0;
      repeat (3) @(posedge sys_clk);
      v = {8'h00, ev(n)};
      `CHK(pendVec, pv(n))
      rc(irq_bank_pkg::OFS_CTRL_A, v[23:16] | 8'h0F);
      rc(irq_bank_pkg::OFS_CTRL_B, v[15:8] | 8'h0F);
      rc(n < 2 ? irq_bank_pkg::OFS_GRP_B : irq_bank_pkg::OFS_GRP_A, v[7:0]);
      clr();
    end
    $display("test events done");
    // prompt and slow core
    for (n = 0; n < 2; n++) begin
      pLag <= 4'(n * 6);
      pEn <= 1'h1;
      wr(irq_bank_pkg::OFS_CTRL_B, 8'h04, irq_bank_pkg::RESP_OKAY);
      wr(irq_bank_pkg::OFS_CTRL_A, 8'h01, irq_bank_pkg::RESP_OKAY);
      @(posedge sys_clk);
      evt.adc <= 1'h1;
      @(posedge sys_clk);
      evt.adc <= 1'h0;
      for (i = 0; i < 20 && irqReq !== 1'h1; i++) @(posedge sys_clk);
      if (i == 20) stop_test(1'h1);
      `CHK(pendVec, 7'h01 << irq_bank_pkg::SRC_ADC)
      repeat (12) @(posedge sys_clk);
      rc(irq_bank_pkg::OFS_CTRL_A, 8'h00);
      rc(irq_bank_pkg::OFS_CTRL_B, 8'h04);
      @(posedge sys_clk);
      evt.tb0 <= 1'h1;
      @(posedge sys_clk);
      evt.tb0 <= 1'h0;
      repeat (3) @(posedge sys_clk);
      rc(irq_bank_pkg::OFS_CTRL_A, 8'h20);
      `CHK(pendVec, 7'h00)
      pEn <= 1'h0;
      clr();
    end
    $display("test take done");
    for (n = 0; n < 4; n++) begin
      wr(irq_bank_pkg::OFS_EDGE, 8'(n), irq_bank_pkg::RESP_OKAY);
      extPin <= 1'h1;
      repeat (8) @(posedge sys_clk);
      rc(irq_bank_pkg::OFS_CTRL_A, n[0] ? 8'h10 : 8'h00);
      wr(irq_bank_pkg::OFS_CTRL_A, 8'h00, irq_bank_pkg::RESP_OKAY);
      extPin <= 1'h0;
      repeat (8) @(posedge sys_clk);
      rc(irq_bank_pkg::OFS_CTRL_A, n[1] ? 8'h10 : 8'h00);
      wr(irq_bank_pkg::OFS_CTRL_A, 8'h00, irq_bank_pkg::RESP_OKAY);
    end
    $display("test pin done");
    stop_test(1'h0);
  end
endmodule
`default_nettype wire
